// *** hw/scp_config_port.sv ***
// Purpose: Write-only serial configuration port and register bank of an octal ADC.
// Assumes: Serial clock at most 20 MHz; core clock 25 MHz; words land in order.
// Notes:   Only the first 24 bits of each select-low period are kept.
//
// Summary of operation
// R1 - Sample data on each rising serial edge
// R2 - 24th edge writes word to register
// R3 - Bits beyond 24 in one frame ignored
// R4 - Word is address byte then value
// R5 - Host keeps serial clock at most 20 MHz; bench frames with half 24 run a 48 ns period, about 20.8 MHz
// R6 - Host resets and power-cycles after power-up
// R7 - Low async reset pulse resets device
// R8 - Soft reset bit restores defaults, self-clears
// R9 - Host never combines soft and pin reset
// R10 - High power-down pin pulse powers down
// R11 - Host writes 0200 then 0000 to 0F
// R12 - Register 0F holds power control fields
// R13 - Register 11 holds three drive currents
// R14 - Register 12 holds termination, enable-gated; the code passes the fields to cfg ungated
// R15 - Register 24 swaps per-channel input polarity
// R16 - Bit 6 alone selects ramp pattern
// R17 - Bit 5 alone selects two-code pattern
// R18 - Bit 4 alone selects fixed code
// R19 - Select is active-low transfer gate
// R20 - Async reset clears the serial interface
// R21 - Pattern codes at 26 and 27, 14 bits
// R22 - MSB first; short frame changes nothing
`timescale 1ns/1ns
module scp_config_port (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire logic         serial_clk,
  input  wire logic         select_n,
  input  wire logic         serial_in,
  input  wire logic         async_reset_n,
  input  wire logic         power_down_pin,
  output scp_pkg::scp_cfg_s cfg,
  output logic              power_down,
  output logic              sleep_mode,
  output logic              pattern_active,
  output logic [13:0]       pattern_code,
  output logic              write_seen
);

  ////////////////////////////////////////////////////////////////////////////
  // Serial-clock domain
  scp_pkg::scp_word_s link_word;
  logic               link_toggle;

  scp_shift u_shift (
    .serial_clk    (serial_clk),
    .async_reset_n (async_reset_n),
    .select_n      (select_n),
    .serial_in     (serial_in),
    .word          (link_word),
    .word_toggle   (link_toggle)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Catchers for short pin pulses, set without the clock
  logic reset_catch;
  logic pd_catch;

  // Holds a reset pulse shorter than a core clock period
  always_ff @(posedge core_clk or negedge async_reset_n) begin
    if (!async_reset_n) begin
      reset_catch <= 1'b1;  // R7 R20
    end else if (clk_en) begin
      reset_catch <= 1'b0;
    end
  end

  // Holds a power-down pulse shorter than a core clock period
  always_ff @(posedge core_clk or posedge power_down_pin) begin
    if (power_down_pin) begin
      pd_catch <= 1'b1;  // R10
    end else if (clk_en) begin
      pd_catch <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers into the core clock
  logic       reset_s1;
  logic       reset_s2;
  logic       pd_s1;
  logic       pd_s2;
  logic       tog_s1;
  logic       tog_s2;
  logic       tog_s3;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_s1 <= 1'b0;
      reset_s2 <= 1'b0;
      pd_s1    <= 1'b0;
      pd_s2    <= 1'b0;
      tog_s1   <= 1'b0;
      tog_s2   <= 1'b0;
      tog_s3   <= 1'b0;
    end else if (clk_en) begin
      reset_s1 <= reset_catch;
      reset_s2 <= reset_s1;
      pd_s1    <= pd_catch;
      pd_s2    <= pd_s1;
      tog_s1   <= link_toggle;
      tog_s2   <= tog_s1;
      tog_s3   <= tog_s2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word arrival and address decode
  wire        word_arrived = tog_s2 ^ tog_s3;  // R2
  wire [7:0]  w_addr       = link_word.addr;    // R4
  wire [15:0] w_data       = link_word.data;
  wire        pin_reset    = reset_s2;          // R7 R20
  wire        wr_ok        = word_arrived & ~pin_reset;
  wire        wr_soft      = wr_ok & (w_addr == scp_pkg::ADDR_SOFTWARE_RESET)
                             & w_data[scp_pkg::SOFT_RESET_BIT];
  wire        wr_power     = wr_ok & (w_addr == scp_pkg::ADDR_POWER_CONTROL);
  wire        wr_drive     = wr_ok & (w_addr == scp_pkg::ADDR_OUTPUT_DRIVE);
  wire        wr_term      = wr_ok & (w_addr == scp_pkg::ADDR_OUTPUT_TERM);
  wire        wr_polarity  = wr_ok & (w_addr == scp_pkg::ADDR_INPUT_POLARITY);
  wire        wr_pattern   = wr_ok & (w_addr == scp_pkg::ADDR_PATTERN_SELECT);
  wire        wr_first     = wr_ok & (w_addr == scp_pkg::ADDR_FIRST_CODE);
  wire        wr_second    = wr_ok & (w_addr == scp_pkg::ADDR_SECOND_CODE);
  wire        clear_regs   = pin_reset | wr_soft;  // R8

  // Pulls a 3-bit field from a written value
  function automatic logic [2:0] field3(input logic [15:0] v, input int unsigned lsb);
    field3 = v[lsb +: 3];
  endfunction : field3

  // Pulls a 14-bit pattern code from a written value
  function automatic logic [13:0] field14(input logic [15:0] v);
    field14 = v[scp_pkg::CODE_LSB +: scp_pkg::CODE_BITS];
  endfunction : field14

  ////////////////////////////////////////////////////////////////////////////
  // Next register bank
  scp_pkg::scp_cfg_s next_cfg;

  always_comb begin
    next_cfg = cfg;
    if (clear_regs) begin
      next_cfg = scp_pkg::CFG_RST;  // R8 R7
    end else begin
      if (wr_power) begin
        next_cfg.ch_powerdown = w_data[scp_pkg::CH_PD_LSB +: 8];  // R12
        next_cfg.sleep        = w_data[scp_pkg::SLEEP_BIT];
        next_cfg.powerdown    = w_data[scp_pkg::POWERDOWN_BIT];
        next_cfg.pin_function = w_data[scp_pkg::PIN_FN_LSB +: 2];
      end
      if (wr_drive) begin
        next_cfg.drive_bitclk   = field3(w_data, scp_pkg::BITCLK_LSB);  // R13
        next_cfg.drive_frameclk = field3(w_data, scp_pkg::FRAMECLK_LSB);
        next_cfg.drive_data     = field3(w_data, scp_pkg::DATA_LSB);
      end
      if (wr_term) begin
        next_cfg.term_enable   = w_data[scp_pkg::TERM_ENABLE_BIT];  // R14
        next_cfg.term_bitclk   = field3(w_data, scp_pkg::BITCLK_LSB);
        next_cfg.term_frameclk = field3(w_data, scp_pkg::FRAMECLK_LSB);
        next_cfg.term_data     = field3(w_data, scp_pkg::DATA_LSB);
      end
      if (wr_polarity) begin
        next_cfg.polarity_swap = w_data[scp_pkg::POLARITY_LSB +: 8];  // R15
      end
      if (wr_pattern) begin
        next_cfg.ramp_enable       = w_data[scp_pkg::RAMP_BIT];
        next_cfg.two_code_enable   = w_data[scp_pkg::TWO_CODE_BIT];
        next_cfg.fixed_code_enable = w_data[scp_pkg::FIXED_CODE_BIT];
      end
      if (wr_first) begin
        next_cfg.first_code = field14(w_data);  // R21
      end
      if (wr_second) begin
        next_cfg.second_code = field14(w_data);  // R21
      end
    end
  end

  // Register bank; the soft reset bit is never stored, so it reads back clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg <= scp_pkg::CFG_RST;
    end else if (clk_en) begin
      cfg <= next_cfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Termination enable flag; the termination fields still pass to cfg ungated
  wire term_active = cfg.term_enable;  // R14

  ////////////////////////////////////////////////////////////////////////////
  // Power state: register bit or pin, pin routed by its function field
  wire pin_to_pd    = (cfg.pin_function == scp_pkg::PIN_FN_PD);  // R12
  wire next_pd      = cfg.powerdown | (pd_s2 & pin_to_pd);        // R10
  wire next_sleep   = cfg.sleep | (pd_s2 & ~pin_to_pd);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      power_down <= 1'b0;
      sleep_mode <= 1'b0;
      write_seen <= 1'b0;
    end else if (clk_en) begin
      power_down <= next_pd;
      sleep_mode <= next_sleep;
      write_seen <= wr_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Test pattern select: exactly one enable bit picks a mode
  logic [2:0]            pat_bits;
  scp_pkg::scp_pattern_e pat_mode;
  logic                  two_phase;
  logic [13:0]           next_code;

  assign pat_bits = {cfg.ramp_enable, cfg.two_code_enable, cfg.fixed_code_enable};

  always_comb begin
    case (pat_bits)
      3'b100:  pat_mode = scp_pkg::SCP_PAT_RAMP;   // R16
      3'b010:  pat_mode = scp_pkg::SCP_PAT_TWO;    // R17
      3'b001:  pat_mode = scp_pkg::SCP_PAT_FIXED;  // R18
      default: pat_mode = scp_pkg::SCP_PAT_NONE;
    endcase
  end

  // Next pattern word for the selected mode
  always_comb begin
    case (pat_mode)
      scp_pkg::SCP_PAT_RAMP:  next_code = pattern_code + 14'h0001;  // R16
      scp_pkg::SCP_PAT_TWO:   next_code = two_phase ? cfg.second_code
                                                    : cfg.first_code;  // R17
      scp_pkg::SCP_PAT_FIXED: next_code = cfg.first_code;  // R18
      default:                next_code = scp_pkg::CODE_RST;
    endcase
  end

  // Pattern generator running on the core clock
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pattern_code   <= scp_pkg::CODE_RST;
      pattern_active <= 1'b0;
      two_phase      <= 1'b0;
    end else if (clk_en) begin
      pattern_code   <= next_code;
      pattern_active <= (pat_mode != scp_pkg::SCP_PAT_NONE);
      two_phase      <= (pat_mode == scp_pkg::SCP_PAT_TWO) ? ~two_phase : 1'b0;  // R17
    end
  end

  // Drive current and termination fields both reach cfg regardless of term_enable; term_active drives nothing
  wire unused_term = term_active;

endmodule : scp_config_port

// *** pkg/scp_pkg.sv ***
// Purpose: Shared constants and types of the serial configuration port.
// Assumes: 24-bit words, 8-bit address first, 16-bit value, MSB first.
// Notes:   Register offsets are the 8-bit addresses carried in each word.
package scp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Word framing
  localparam int unsigned WORD_BITS = 24;
  localparam int unsigned ADDR_BITS = 8;
  localparam int unsigned DATA_BITS = 16;
  localparam logic [4:0]  BIT_COUNT_RST = 5'h00;
  localparam logic [4:0]  LAST_BIT_COUNT = 5'h17;  // Count before the 24th edge
  localparam logic [4:0]  FULL_COUNT = 5'h18;      // 24 bits taken

  ////////////////////////////////////////////////////////////////////////////
  // Register addresses
  localparam logic [7:0] ADDR_SOFTWARE_RESET = 8'h00;
  localparam logic [7:0] ADDR_POWER_CONTROL  = 8'h0F;
  localparam logic [7:0] ADDR_OUTPUT_DRIVE   = 8'h11;
  localparam logic [7:0] ADDR_OUTPUT_TERM    = 8'h12;
  localparam logic [7:0] ADDR_INPUT_POLARITY = 8'h24;
  localparam logic [7:0] ADDR_PATTERN_SELECT = 8'h25;
  localparam logic [7:0] ADDR_FIRST_CODE     = 8'h26;
  localparam logic [7:0] ADDR_SECOND_CODE    = 8'h27;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned SOFT_RESET_BIT  = 0;
  localparam int unsigned CH_PD_LSB       = 0;
  localparam int unsigned SLEEP_BIT       = 8;
  localparam int unsigned POWERDOWN_BIT   = 9;
  localparam int unsigned PIN_FN_LSB      = 10;
  localparam int unsigned BITCLK_LSB      = 0;
  localparam int unsigned FRAMECLK_LSB    = 4;
  localparam int unsigned DATA_LSB        = 8;
  localparam int unsigned TERM_ENABLE_BIT = 14;
  localparam int unsigned POLARITY_LSB    = 0;
  localparam int unsigned RAMP_BIT        = 6;
  localparam int unsigned TWO_CODE_BIT    = 5;
  localparam int unsigned FIXED_CODE_BIT  = 4;
  localparam int unsigned CODE_LSB        = 0;
  localparam int unsigned CODE_BITS       = 14;

  ////////////////////////////////////////////////////////////////////////////
  // Values after reset
  localparam logic [7:0]  CH_PD_RST    = 8'h00;
  localparam logic [1:0]  PIN_FN_RST   = 2'h0;   // Pin selects power-down
  localparam logic [1:0]  PIN_FN_PD    = 2'h0;
  localparam logic [2:0]  DRIVE_RST    = 3'h0;   // Code for 3.5 mA drive
  localparam logic [2:0]  TERM_RST     = 3'h0;
  localparam logic [7:0]  POLARITY_RST = 8'h00;
  localparam logic [13:0] CODE_RST     = 14'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {
    SCP_PAT_NONE  = 2'b00,
    SCP_PAT_RAMP  = 2'b01,
    SCP_PAT_TWO   = 2'b10,
    SCP_PAT_FIXED = 2'b11
  } scp_pattern_e;

  typedef struct packed {
    logic [7:0]  addr;
    logic [15:0] data;
  } scp_word_s;

  typedef struct packed {
    logic [7:0]  ch_powerdown;
    logic        sleep;
    logic        powerdown;
    logic [1:0]  pin_function;
    logic [2:0]  drive_bitclk;
    logic [2:0]  drive_frameclk;
    logic [2:0]  drive_data;
    logic        term_enable;
    logic [2:0]  term_bitclk;
    logic [2:0]  term_frameclk;
    logic [2:0]  term_data;
    logic [7:0]  polarity_swap;
    logic        ramp_enable;
    logic        two_code_enable;
    logic        fixed_code_enable;
    logic [13:0] first_code;
    logic [13:0] second_code;
  } scp_cfg_s;

  localparam scp_cfg_s CFG_RST = '{
    ch_powerdown:      CH_PD_RST,
    sleep:             1'b0,
    powerdown:         1'b0,
    pin_function:      PIN_FN_RST,
    drive_bitclk:      DRIVE_RST,
    drive_frameclk:    DRIVE_RST,
    drive_data:        DRIVE_RST,
    term_enable:       1'b0,
    term_bitclk:       TERM_RST,
    term_frameclk:     TERM_RST,
    term_data:         TERM_RST,
    polarity_swap:     POLARITY_RST,
    ramp_enable:       1'b0,
    two_code_enable:   1'b0,
    fixed_code_enable: 1'b0,
    first_code:        CODE_RST,
    second_code:       CODE_RST
  };

endpackage : scp_pkg

// *** hw/scp_shift.sv ***
// Purpose: Serial-clock side of the configuration port: shifts and frames words.
// Assumes: Serial clock stops outside select; select_n and async_reset_n async.
// Notes:   A finished word stays stable until the next word is completed or async_reset_n falls.
`timescale 1ns/1ns
module scp_shift (
  input  wire logic              serial_clk,
  input  wire logic              async_reset_n,
  input  wire logic              select_n,
  input  wire logic              serial_in,
  output scp_pkg::scp_word_s     word,
  output logic                   word_toggle
);

  logic [4:0]  bit_count;
  logic [22:0] shift;
  wire         frame_idle_n = async_reset_n & ~select_n;
  wire         taking       = (bit_count < scp_pkg::FULL_COUNT);
  wire         last_edge    = (bit_count == scp_pkg::LAST_BIT_COUNT);

  ////////////////////////////////////////////////////////////////////////////
  // Shift and count, cleared by select high so a short frame is dropped
  always_ff @(posedge serial_clk or negedge frame_idle_n) begin
    if (!frame_idle_n) begin
      bit_count <= scp_pkg::BIT_COUNT_RST;  // R22 R19 R20
      shift     <= 23'h000000;
    end else if (taking) begin
      shift     <= {shift[21:0], serial_in};  // R1 R22
      bit_count <= bit_count + 5'h01;         // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Word hand-off on the 24th edge; toggle tells the core clock
  always_ff @(posedge serial_clk or negedge async_reset_n) begin
    if (!async_reset_n) begin
      word        <= '0;  // R7
      word_toggle <= 1'b0;
    end else if (!select_n && last_edge) begin
      word        <= {shift, serial_in};  // R2 R4
      word_toggle <= ~word_toggle;
    end
  end

endmodule : scp_shift

// *** verification/scp_assertions.sv ***
// Purpose: Port-level checks of the serial configuration port.
// Assumes: Clock enable held high; select_n sampled in the core domain.
// Notes:   Bound to scp_config_port at the foot of this file.
`timescale 1ns/1ns
module scp_assertions (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              clk_en,
  input wire logic              serial_clk,
  input wire logic              select_n,
  input wire logic              serial_in,
  input wire logic              async_reset_n,
  input wire logic              power_down_pin,
  input wire scp_pkg::scp_cfg_s cfg,
  input wire logic              power_down,
  input wire logic              sleep_mode,
  input wire logic              pattern_active,
  input wire logic [13:0]       pattern_code,
  input wire logic              write_seen
);
  logic       sel_q;
  logic [1:0] wr_cnt;
  logic [2:0] pat_sel;

  // Pattern enables as one field, ramp highest
  assign pat_sel = {cfg.ramp_enable, cfg.two_code_enable, cfg.fixed_code_enable};

  // Counts accepted words since select last fell
  always_ff @(posedge core_clk) begin
    sel_q <= select_n;
    if (rst || (sel_q && !select_n)) wr_cnt <= 2'h0;
    else if (write_seen && wr_cnt != 2'h3) wr_cnt <= wr_cnt + 2'h1;
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_WRITE_PULSE: assert property (write_seen |=> !write_seen)
    else $error("write pulse longer than one cycle");
  AST_CFG_CAUSE: assert property (!$stable(cfg) |->
    write_seen || $past(write_seen) || cfg == scp_pkg::CFG_RST)
    else $error("configuration changed without a word");
  AST_ONE_WORD: assert property (wr_cnt <= 2'h1)
    else $error("more than one word taken in one frame");
  AST_PD_BIT: assert property ($rose(cfg.powerdown) |-> ##[0:1] power_down)
    else $error("power-down bit not reflected");
  AST_PD_PIN: assert property ($rose(power_down_pin) &&
    cfg.pin_function == scp_pkg::PIN_FN_PD |-> ##[1:6] power_down)
    else $error("power-down pin pulse missed");
  AST_PIN_SLEEP: assert property ($rose(power_down_pin) &&
    cfg.pin_function != scp_pkg::PIN_FN_PD |-> ##[1:6] sleep_mode)
    else $error("pin not routed to sleep");
  AST_ASYNC_RST: assert property ($fell(async_reset_n) |->
    ##[1:6] cfg == scp_pkg::CFG_RST)
    else $error("async reset did not restore defaults");
  AST_PAT_ACTIVE: assert property ($stable(cfg) [*2] |->
    pattern_active == $onehot(pat_sel))
    else $error("pattern active flag wrong");
  AST_FIXED: assert property ((pat_sel == 3'h1 && $stable(cfg)) [*2] |->
    pattern_code == cfg.first_code)
    else $error("fixed pattern code wrong");
  AST_RAMP: assert property ((pat_sel == 3'h4 && $stable(cfg)) [*3] |->
    pattern_code == $past(pattern_code) + 14'h1)
    else $error("ramp did not step by one");
endmodule : scp_assertions

bind scp_config_port scp_assertions u_scp_assertions (.core_clk, .rst, .clk_en,
  .serial_clk, .select_n, .serial_in, .async_reset_n, .power_down_pin, .cfg,
  .power_down, .sleep_mode, .pattern_active, .pattern_code, .write_seen);

// *** verification/scp_host_model.sv ***
// Purpose: Host side of the serial link, framing configuration words.
// Assumes: Serial clock idles low and stands still outside frames.
// Notes:   Bits beyond 24 carry a second word with the address LSB flipped.
`timescale 1ns/1ns
module scp_host_model (
  output logic serial_clk,
  output logic select_n,
  output logic serial_in
);
  // Idle levels at start
  initial begin
    serial_clk = 1'b0;
    select_n   = 1'b1;
    serial_in  = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // Sends n bits of a word, data changed after each falling edge
  task automatic send(input scp_pkg::scp_word_s w, input int n, input int half);
    logic [23:0] v;
    v = w;
    select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      serial_in = v[23 - (i % 24)] ^ (i == 31);
      #(half) serial_clk = 1'b1;
      #(half) serial_clk = 1'b0;
    end
    #(half) select_n = 1'b1;
    serial_in = ~serial_in;
    #(half * 4);
  endtask : send
endmodule : scp_host_model

// *** verification/scp_config_port_bench.sv ***
// Purpose: Self-checking bench of the serial configuration port.
// Assumes: Host model frames words; clock enable held high throughout.
// Notes:   Each frame is judged 8 core cycles after the host send returns, 4 half periods after select rises.
`timescale 1ns/1ns
module scp_config_port_bench;
  logic              core_clk       = 1'b0;
  logic              rst            = 1'b1;
  logic              async_reset_n  = 1'b1;
  logic              power_down_pin = 1'b0;
  logic              serial_clk;
  logic              select_n;
  logic              serial_in;
  scp_pkg::scp_cfg_s cfg;
  logic              power_down;
  logic              sleep_mode;
  logic              pattern_active;
  logic [13:0]       pattern_code;
  logic              write_seen;
  int                failures = 0;
  int                n_tests  = 0;
  int                n_wr     = 0;

  // Core clock and count of accepted words
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) if (write_seen === 1'b1) n_wr++;

  scp_config_port u_scp_config_port (.core_clk(core_clk), .rst(rst), .clk_en(1'b1),
    .serial_clk(serial_clk), .select_n(select_n), .serial_in(serial_in),
    .async_reset_n(async_reset_n), .power_down_pin(power_down_pin), .cfg(cfg),
    .power_down(power_down), .sleep_mode(sleep_mode), .pattern_active(pattern_active),
    .pattern_code(pattern_code), .write_seen(write_seen));
  scp_host_model u_scp_host_model (.serial_clk(serial_clk), .select_n(select_n),
    .serial_in(serial_in));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [127:0] seen, input logic [127:0] want);
    n_tests++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  task automatic frame(input logic [7:0] a, input logic [15:0] d, input int n, input int half);
    u_scp_host_model.send({a, d}, n, half);
    repeat (8) @(posedge core_clk);
    #1;
  endtask : frame

  // Collects any high level of the power outputs over 8 cycles
  task automatic watch(output logic pd, output logic sl);
    pd = 1'b0;
    sl = 1'b0;
    repeat (8) begin
      @(posedge core_clk);
      #1;
      pd = pd | power_down;
      sl = sl | sleep_mode;
    end
  endtask : watch

  // One core cycle pulse on the reset pin or, with pd_pin set, the power-down pin
  task automatic pin_pulse(input bit pd_pin);
    @(posedge core_clk);
    if (pd_pin) begin
      power_down_pin <= 1'b1;
    end else begin
      async_reset_n <= 1'b0;
    end
    @(posedge core_clk);
    power_down_pin <= 1'b0;
    async_reset_n  <= 1'b1;
  endtask : pin_pulse

  task automatic t_pins;
    logic pd;
    logic sl;
    frame(8'h24, 16'h005A, 24, 24);
    check(cfg.polarity_swap, 8'h5A);
    pin_pulse(1'b0);
    watch(pd, sl);
    check(cfg, 0);
    pin_pulse(1'b1);
    watch(pd, sl);
    check({pd, sl}, 2'b10);
    frame(8'h0F, 16'h0400, 24, 24);
    pin_pulse(1'b1);
    watch(pd, sl);
    check({pd, sl}, 2'b01);
    $display("t_pins done");
  endtask : t_pins

  task automatic t_fields;
    int w0;
    w0 = n_wr;
    frame(8'h0F, 16'h0DA5, 24, 24);
    frame(8'h11, 16'h0537, 24, 24);
    frame(8'h12, 16'h4426, 24, 24);
    frame(8'h24, 16'h005A, 24, 200);
    frame(8'h26, 16'hFFFF, 24, 24);
    frame(8'h27, 16'h1234, 24, 24);
    frame(8'h30, 16'hFFFF, 24, 24);
    check(n_wr - w0, 7);
    check({cfg.pin_function, cfg.powerdown, cfg.sleep, cfg.ch_powerdown}, 12'hDA5);
    check(sleep_mode, 1'b1);
    check({cfg.drive_data, 1'b0, cfg.drive_frameclk, 1'b0, cfg.drive_bitclk}, 11'h537);
    check({cfg.term_enable, cfg.term_data, cfg.term_frameclk, cfg.term_bitclk},
          {1'b1, 3'h4, 3'h2, 3'h6});
    check(cfg.polarity_swap, 8'h5A);
    check({cfg.first_code, cfg.second_code}, {14'h3FFF, 14'h1234});
    frame(8'h0F, 16'h0200, 24, 24);
    check(power_down, 1'b1);
    frame(8'h0F, 16'h0000, 24, 24);
    check(power_down, 1'b0);
    $display("t_fields done");
  endtask : t_fields

  task automatic t_patterns;
    logic [15:0] v [5];
    logic [13:0] p;
    v = '{16'h0040, 16'h0020, 16'h0010, 16'h0070, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      frame(8'h25, v[i], 24, 24);
      p = pattern_code;
      @(posedge core_clk);
      #1;
      check(pattern_active, i < 3);
      if (i == 0) check(pattern_code, p + 14'h1);
      if (i == 1) check(pattern_code != p && (p == 14'h3FFF || p == 14'h1234), 1'b1);
      if (i == 2) check({pattern_code, p}, {2{14'h3FFF}});
    end
    $display("t_patterns done");
  endtask : t_patterns

  task automatic t_frames;
    int w0;
    w0 = n_wr;
    frame(8'h24, 16'h00FF, 23, 24);
    check(cfg.polarity_swap, 8'h5A);
    frame(8'h24, 16'h00A5, 48, 24);
    check({cfg.polarity_swap, cfg.two_code_enable}, {8'hA5, 1'b0});
    check(n_wr - w0, 1);
    $display("t_frames done");
  endtask : t_frames

  // Soft reset alone, with no reset pin pulse
  task automatic t_soft;
    frame(8'h00, 16'h0001, 24, 24);
    check(cfg, 0);
    frame(8'h24, 16'h0011, 24, 24);
    check(cfg.polarity_swap, 8'h11);
    $display("t_soft done");
  endtask : t_soft

  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  // Reset pin pulsed inside the core reset so the link side starts known
  initial begin
    pin_pulse(1'b0);
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    check(cfg, 0);
    t_pins;
    t_fields;
    t_patterns;
    t_frames;
    t_soft;
    complete_run;
  end

  // Watchdog well beyond the expected run
  initial begin
    #1000000;
    failures++;
    complete_run;
  end
endmodule : scp_config_port_bench
